// ### logic/gpg_defines.vh
// Register offsets, reset values and package codes for the general port G block.
`ifndef GPG_DEFINES_VH
`define GPG_DEFINES_VH
`define GPG_OFF_PIN_LEVELS 12'h000
`define GPG_OFF_OUTPUT_LATCH 12'h004
`define GPG_OFF_DIRECTION 12'h008
`define GPG_OFF_PERIPH_CTRL 12'h00C
`define GPG_OFF_PERIPH_STAT 12'h010
`define GPG_RST_LATCH 8'h00
`define GPG_RST_DIRECTION 8'hFF
`define GPG_RST_CTRL 8'h00
`define GPG_PKG_SMALL 2'h0
`define GPG_PKG_MIDDLE 2'h1
`define GPG_PKG_LARGE 2'h2
`define GPG_MASK_SMALL 8'h10
`define GPG_MASK_MIDDLE 8'h1F
`define GPG_MASK_LARGE 8'hFF
// Peripheral control register fields.
`define GPG_CTL_EU3_CMP 0
`define GPG_CTL_EU3_PWMA 1
`define GPG_CTL_CC4_CMP 2
`define GPG_CTL_EU3_PWMD 3
`define GPG_CTL_CC5_CMP 4
`define GPG_CTL_EU1_PWMD 5
`define GPG_CTL_SER_TX 6
`define GPG_CTL_SER_RX 7
`endif

// ### logic/gpg_port.v
// General-purpose port G: registers, pin drivers and peripheral overrides.
//
// Behaviour
// (R01) Width set by package: bit 4 only, bits 4..0, or bits 7..0.
// (R02) Direction bit one puts the pin driver in high impedance.
// (R03) Direction bit zero drives the pin from its output latch bit.
// (R04) Latch register reads return latch contents, not pin levels.
// (R05) Enabled peripherals may force pin direction to output or input.
// (R06) Forced direction is never stored; direction register reads software values.
// (R07) Bit 0 unit-three compare output overrides latch; direction one feeds capture.
// (R08) Bit 0 PWM channel A overrides port and parallel data; may float on shutdown.
// (R09) Serial transmit or sync data on bits 1 or 2 overrides port data.
// (R10) Software sets bit 2 direction to input when sync data receives.
// (R11) Bit 1 feeds serial sync clock input in clock-receiving mode with direction one.
// (R12) Bit 2 feeds serial receive input when receiver active with direction one.
// (R13) Bit 3 compare four output overrides port data; direction one feeds capture.
// (R14) Bit 3 PWM channel D overrides port and parallel data; may float on shutdown.
// (R15) Bit 4 compare five output overrides port data; direction one feeds capture.
// (R16) Bit 4 other unit's PWM channel D overrides data; may float on shutdown.
// (R17) Port writes update the latch; port reads return sampled pin levels.
//
// The APB register port and the placing of the registers were left to the implementer.
`include "gpg_defines.vh"
`default_nettype none
module gpg_port #(
    parameter [1:0] PKG_OPTION = `GPG_PKG_LARGE
) (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Pins
    input wire [7:0] pin_in,
    output reg [7:0] pin_out,
    output reg [7:0] pin_oe,
    // Peripheral outputs and shutdown
    input wire enh_capture_unit_three_cmp,
    input wire unit_three_pwm_chan_a,
    input wire unit_three_pwm_chan_d,
    input wire unit_one_pwm_chan_d,
    input wire capture_compare_four_cmp,
    input wire capture_compare_five_cmp,
    input wire unit_three_shutdown_float,
    input wire unit_one_shutdown_float,
    input wire serial_transmit_out,
    input wire serial_sync_data_out,
    input wire serial_sync_mode,
    input wire serial_sync_clock_slave,
    input wire serial_sync_data_drive,
    // Peripheral inputs taken from pins
    output reg enh_capture_unit_three_cap,
    output reg capture_compare_four_cap,
    output reg capture_compare_five_cap,
    output reg serial_sync_clock,
    output reg serial_receive_in
);

    // Pins absent from the chosen package never drive; their level and latch bits read as zero, their direction bits as one. [R01]
    localparam [7:0] PMASK = (PKG_OPTION == `GPG_PKG_SMALL) ? `GPG_MASK_SMALL :
                             (PKG_OPTION == `GPG_PKG_MIDDLE) ? `GPG_MASK_MIDDLE :
                             `GPG_MASK_LARGE;

    reg [7:0] output_latch_bits_r;
    reg [7:0] pin_direction_bits_r;
    reg [7:0] periph_ctrl_r;
    reg [7:0] pin_meta_r;
    reg [7:0] pin_level_port_r;
    reg [7:0] pin_out_nxt;
    reg [7:0] pin_oe_nxt;
    reg [31:0] rdata_nxt;
    reg err_nxt;

    wire setup = psel && !penable;
    wire wr_now = psel && penable && pwrite && pready;
    wire [7:0] wbyte = pwdata[7:0] & PMASK;
    wire [7:0] dir = pin_direction_bits_r;
    wire [7:0] ctl = periph_ctrl_r;
    wire sync_data_tx = ctl[`GPG_CTL_SER_TX] && serial_sync_mode && serial_sync_data_drive;

    // Synchroniser; only the second stage is read by logic.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_r <= 8'h00;
            pin_level_port_r <= 8'h00;
        end else begin
            pin_meta_r <= pin_in;
            pin_level_port_r <= pin_meta_r & PMASK;
        end
    end

    // Pin driver mux; peripheral overrides never touch the direction register. [R05] [R06]
    always @* begin
        pin_out_nxt = output_latch_bits_r;
        pin_oe_nxt = ~dir; // [R02] [R03]
        // Bit 0: PWM channel A wins over compare output and latch. [R07] [R08]
        if (ctl[`GPG_CTL_EU3_PWMA] && !dir[0]) begin
            pin_out_nxt[0] = unit_three_pwm_chan_a;
            pin_oe_nxt[0] = !unit_three_shutdown_float;
        end else if (ctl[`GPG_CTL_EU3_CMP] && !dir[0]) begin
            pin_out_nxt[0] = enh_capture_unit_three_cmp;
        end
        // Serial outputs drive even with direction set to input. [R09]
        if (ctl[`GPG_CTL_SER_TX]) begin
            if (serial_sync_mode) begin
                if (!serial_sync_clock_slave) begin
                    pin_out_nxt[1] = serial_transmit_out;
                    pin_oe_nxt[1] = 1'b1;
                end
            end else begin
                pin_out_nxt[1] = serial_transmit_out;
                pin_oe_nxt[1] = 1'b1;
            end
        end
        if (sync_data_tx) begin
            pin_out_nxt[2] = serial_sync_data_out;
            pin_oe_nxt[2] = 1'b1; // [R09]
        end
        // Bit 3. [R13] [R14]
        if (ctl[`GPG_CTL_EU3_PWMD] && !dir[3]) begin
            pin_out_nxt[3] = unit_three_pwm_chan_d;
            pin_oe_nxt[3] = !unit_three_shutdown_float;
        end else if (ctl[`GPG_CTL_CC4_CMP] && !dir[3]) begin
            pin_out_nxt[3] = capture_compare_four_cmp;
        end
        // Bit 4. [R15] [R16]
        if (ctl[`GPG_CTL_EU1_PWMD] && !dir[4]) begin
            pin_out_nxt[4] = unit_one_pwm_chan_d;
            pin_oe_nxt[4] = !unit_one_shutdown_float;
        end else if (ctl[`GPG_CTL_CC5_CMP] && !dir[4]) begin
            pin_out_nxt[4] = capture_compare_five_cmp;
        end
        pin_out_nxt = pin_out_nxt & PMASK; // [R01]
        pin_oe_nxt = pin_oe_nxt & PMASK;
    end

    // Read mux for the access phase.
    always @* begin
        rdata_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        case (paddr)
            `GPG_OFF_PIN_LEVELS: rdata_nxt[7:0] = pin_level_port_r; // [R17]
            `GPG_OFF_OUTPUT_LATCH: rdata_nxt[7:0] = output_latch_bits_r; // [R04]
            `GPG_OFF_DIRECTION: rdata_nxt[7:0] = pin_direction_bits_r; // [R06]
            `GPG_OFF_PERIPH_CTRL: rdata_nxt[7:0] = periph_ctrl_r;
            `GPG_OFF_PERIPH_STAT: rdata_nxt[7:0] = pin_oe_nxt;
            default: err_nxt = 1'b1;
        endcase
    end

    // APB: one wait-free access phase; pready rises the cycle after setup.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup & err_nxt;
            if (setup && !pwrite) begin
                prdata <= rdata_nxt;
            end else if (!setup) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_latch_bits_r <= `GPG_RST_LATCH;
            pin_direction_bits_r <= `GPG_RST_DIRECTION;
            periph_ctrl_r <= `GPG_RST_CTRL;
        end else if (wr_now) begin
            case (paddr)
                // Both the port and latch offsets write the latch. [R04] [R17]
                `GPG_OFF_PIN_LEVELS: output_latch_bits_r <= wbyte;
                `GPG_OFF_OUTPUT_LATCH: output_latch_bits_r <= wbyte;
                `GPG_OFF_DIRECTION: pin_direction_bits_r <= wbyte | ~PMASK;
                `GPG_OFF_PERIPH_CTRL: periph_ctrl_r <= pwdata[7:0];
                default: periph_ctrl_r <= periph_ctrl_r;
            endcase
        end
    end

    // Registered pin drivers and peripheral inputs.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
            enh_capture_unit_three_cap <= 1'b0;
            capture_compare_four_cap <= 1'b0;
            capture_compare_five_cap <= 1'b0;
            serial_sync_clock <= 1'b0;
            serial_receive_in <= 1'b1;
        end else begin
            pin_out <= pin_out_nxt;
            pin_oe <= pin_oe_nxt;
            enh_capture_unit_three_cap <= dir[0] & pin_level_port_r[0]; // [R07]
            capture_compare_four_cap <= dir[3] & pin_level_port_r[3]; // [R13]
            capture_compare_five_cap <= dir[4] & pin_level_port_r[4]; // [R15]
            // Clock-receiving sync mode takes the clock from bit 1. [R11]
            serial_sync_clock <= serial_sync_mode & serial_sync_clock_slave & dir[1]
                & pin_level_port_r[1];
            // Receive path is idle high unless the receiver owns bit 2. [R12] [R10]
            serial_receive_in <= (ctl[`GPG_CTL_SER_RX] && dir[2]) ? pin_level_port_r[2] : 1'b1;
        end
    end

endmodule
`default_nettype wire

// ### dv/gpg_port_asserts.sv
// Port G checker: bus answer, register read-back and pin drive.
`default_nettype none
module gpg_chk (
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [7:0] pin_oe, pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lat_r, dir_r;
    wire rd = psel && pready && !pwrite;
    wire wr = psel && pready && pwrite;
    // Bits 7..5 have no peripheral, so the shadows alone predict them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_r <= 8'h00;
            dir_r <= 8'hFF;
        end else if (wr && paddr < 12'h008) begin
            lat_r <= pwdata[7:0];
        end else if (wr && paddr == 12'h008) begin
            dir_r <= pwdata[7:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ans; psel && !penable |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("long answer");
    property p_idle; !pready |-> prdata == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("stale data");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("lone error");
    property p_lat; rd && paddr == 12'h004 |-> prdata[7:0] == lat_r; endproperty
    a_lat: assert property (p_lat) else $error("latch read");
    property p_dir; rd && paddr == 12'h008 |-> prdata[7:0] == dir_r; endproperty
    a_dir: assert property (p_dir) else $error("direction read");
    property p_hiz; (pin_oe & 8'hE0) == (~$past(dir_r) & 8'hE0); endproperty
    a_hiz: assert property (p_hiz) else $error("pin enable");
    property p_drv; (pin_oe & pin_out & 8'hE0) == (pin_oe & $past(lat_r) & 8'hE0); endproperty
    a_drv: assert property (p_drv) else $error("pin level");
    c_err: cover property (pslverr);
    c_lat: cover property (rd && paddr == 12'h004);
    c_drv: cover property (pin_oe == 8'hFF);
endmodule
bind gpg_port gpg_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pin_oe(pin_oe), .pin_out(pin_out));
`default_nettype wire

// ### dv/gpg_board.sv
// Board model: pull-ups, an outside driver and the port's own drive.
`default_nettype none
module gpg_board (
    input wire logic [7:0] pin_out, pin_oe, ext_val, ext_en,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins nobody drives float high, so a lucky zero cannot pass.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (~ext_en | ext_val));
endmodule
`default_nettype wire

// ### dv/tb_general_port_g_io.sv
// Port G testbench: registers, pin drive and peripheral overrides.
`default_nettype none
module tb_general_port_g_io;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, rx, er, c3, c4, c5, sck;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [7:0] pin_in, pin_out, pin_oe, q, ext_val = 8'h00, ext_en = 8'h00;
    logic [12:0] pv = 13'h0000;
    int bad_count = 0, total_checks = 0, cyc = 0;
    gpg_board brd_u (.*);
    gpg_port dut_u (.*, .enh_capture_unit_three_cmp(pv[0]), .unit_three_pwm_chan_a(pv[1]),
        .unit_three_pwm_chan_d(pv[2]), .unit_one_pwm_chan_d(pv[3]),
        .capture_compare_four_cmp(pv[4]), .capture_compare_five_cmp(pv[5]),
        .unit_three_shutdown_float(pv[6]), .unit_one_shutdown_float(pv[7]),
        .serial_transmit_out(pv[8]), .serial_sync_data_out(pv[9]), .serial_sync_mode(pv[10]),
        .serial_sync_clock_slave(pv[11]), .serial_sync_data_drive(pv[12]),
        .enh_capture_unit_three_cap(c3), .capture_compare_four_cap(c4),
        .capture_compare_five_cap(c5), .serial_sync_clock(sck), .serial_receive_in(rx));
    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) if (++cyc == 3000) begin
        bad_count++;
        print_verdict();
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk("prdata", e, q);
    endtask
    task automatic t_regs;
        rd(12'h004, 8'h00);
        rd(12'h008, 8'hFF);
        rd(12'h014, 8'h00);
        chk("pslverr", 8'h01, {7'h00, er});
        $display("t_regs done");
    endtask
    task automatic t_pins;
        apb(1'b1, 12'h008, 8'h00);
        apb(1'b1, 12'h000, 8'hA5);
        rd(12'h004, 8'hA5);
        chk("pin_out", 8'hA5, pin_out & pin_oe);
        rd(12'h000, 8'hA5);
        ext_val <= 8'h38;
        ext_en <= 8'hFF;
        apb(1'b1, 12'h008, 8'hF0);
        chk("pin_oe", 8'h0F, pin_oe);
        rd(12'h000, 8'h35);
        rd(12'h004, 8'hA5);
        $display("t_pins done");
    endtask
    task automatic t_periph;
        apb(1'b1, 12'h004, 8'h00);
        apb(1'b1, 12'h008, 8'hFE);
        pv <= 13'h0001;
        apb(1'b1, 12'h00C, 8'h01);
        chk("pin_out", 8'h01, pin_out & 8'h01);
        pv <= 13'h0002;
        apb(1'b1, 12'h00C, 8'h03);
        chk("pin_out", 8'h01, pin_out & 8'h01);
        pv <= 13'h0042;
        rd(12'h008, 8'hFE);
        chk("pin_oe", 8'h00, pin_oe & 8'h01);
        pv <= 13'h0100;
        apb(1'b1, 12'h00C, 8'hC0);
        chk("pin_oe", 8'h02, pin_oe & 8'h06);
        chk("pin_out", 8'h02, pin_out & 8'h02);
        chk("rx", 8'h00, {7'h00, rx});
        $display("t_periph done");
    endtask
    task automatic t_more;
        apb(1'b1, 12'h008, 8'h00);
        pv <= 13'h000C;
        apb(1'b1, 12'h00C, 8'h3C);
        chk("pin_out", 8'h18, pin_out & 8'h18);
        pv <= 13'h008C;
        repeat (2) @(posedge pclk);
        chk("pin_oe", 8'h08, pin_oe & 8'h18);
        pv <= 13'h0030;
        apb(1'b1, 12'h00C, 8'h14);
        chk("pin_out", 8'h18, pin_out & 8'h18);
        apb(1'b1, 12'h00C, 8'h00);
        pv <= 13'h0C00;
        ext_val <= 8'h1B;
        apb(1'b1, 12'h008, 8'hFF);
        // Pin release, two sync stages and the capture register need four edges.
        repeat (4) @(posedge pclk);
        chk("caps", 8'h0F, {4'h0, sck, c5, c4, c3});
        $display("t_more done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_pins();
        t_periph();
        t_more();
        print_verdict();
    end
endmodule
`default_nettype wire
